// ---- hdl/dfm_top.sv ----
// Digital input and output function map of a servo drive.
//
// Summary of operation
// - Servo enable follows input, non-bus mode only.
// - Fault clear acts only in non-bus mode.
// - Forward limit active inhibits forward motion.
// - Reverse limit active inhibits reverse motion.
// - Home reference is a plain level.
// - Emergency halt is a plain level; stopping is left to the core.
// - Latch triggers only arm probe capture.
// - Ready output follows drive ready.
// - Rotating output when speed reaches threshold.
// - Brake output follows brake signal.
// - Warning output follows warning present.
// - Fault output follows fault present.
// - Compare output when comparison point passed.
// - Safety output when both supplies lost.
// - Forced inputs ignore terminal levels entirely.
// - Selection decodes none, in, out, both, bus.
// - Selection resets zero, writable, acts immediately.
// - Forced input bit one gives high level; forced output bit one gives activity.
// - Polarity per input; levels readable.
// - Bit zero is input one, ascending.
// - Reset or selection zero restores terminals.
// - Bus forcing uses bits sixteen upward.
`timescale 1ns/100ps
`default_nettype none
`include "dfm_defs.svh"
module dfm_top
  import dfm_pkg::*;
#(
  parameter int NUM_DI = 5,                          // Number of input terminals.
  parameter int NUM_DO = 3                           // Number of output terminals.
) (
  input  wire logic                   mclk,              // Control clock, 200 MHz.
  input  wire logic                   rst_n,             // Synchronous reset, active low.
  input  wire logic [NUM_DI-1:0]      di_pin,            // Terminal input levels.
  input  wire logic [NUM_DI-1:0]      di_active_low,     // Input polarity, 1 is active low.
  input  wire logic [23:0]            in_fn_map,         // Terminal number per function.
  input  wire logic [NUM_DO*6-1:0]    do_fn_code,        // Function code per output.
  input  wire logic [NUM_DO-1:0]      do_active_low,     // Output polarity, 1 is active low.
  input  wire logic [NUM_DO-1:0]      forced_do_active,  // Forced output activity.
  input  wire logic [31:0]            fieldbus_out_en,   // Fieldbus output enable object.
  input  wire logic [31:0]            fieldbus_out_val,  // Fieldbus output object.
  input  wire logic                   bus_control_mode,  // High in bus control mode.
  input  wire logic [15:0]            rotation_speed_threshold, // Rotation threshold.
  input  wire dfm_status_t            drive_status,      // Internal drive status.
  input  wire logic                   par_wr,            // Parameter write strobe.
  input  wire logic [1:0]             par_idx,           // Parameter index.
  input  wire logic [15:0]            par_wdata,         // Parameter write data.
  output logic [15:0]                 par_rdata_reg,     // Parameter read data.
  output dfm_in_fn_t                  in_fn_reg,         // Input function commands.
  output logic [NUM_DO-1:0]           do_pin_reg,        // Terminal output levels.
  output logic [15:0]                 io_forcing_select_reg // Forcing selection.
);

  // Terminal numbers are three bits wide, so at most seven inputs can be
  // assigned; outputs are capped at eight, inside the sixteen bits of the fieldbus window.
  if (NUM_DI < 1 || NUM_DI > 7 || NUM_DO < 1 || NUM_DO > 8) begin : g_bad_counts
    $error("dfm_top: terminal counts out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter storage.

  logic [15:0]       forced_input_levels_reg;  // Forced input levels.
  logic [15:0]       forced_input_levels_next; // Next forced input levels.
  logic [15:0]       force_sel_next;           // Next forcing selection.
  logic [15:0]       par_rdata_next;           // Next read data.
  logic [NUM_DI-1:0] monitored_input_levels_reg; // Levels seen by functions.
  dfm_mode_t         mode;                     // Decoded forcing selection.

  // Writes take effect at once, even while the drive runs.
  always_comb begin
    force_sel_next           = io_forcing_select_reg;
    forced_input_levels_next = forced_input_levels_reg;
    par_rdata_next           = 16'h0000;
    if (par_wr && par_idx == `DFM_IDX_FORCE_SEL) begin
      force_sel_next = par_wdata;
    end
    if (par_wr && par_idx == `DFM_IDX_FORCED_IN) begin
      forced_input_levels_next = par_wdata;
    end
    case (par_idx)
      `DFM_IDX_FORCE_SEL: par_rdata_next = io_forcing_select_reg;
      `DFM_IDX_FORCED_IN: par_rdata_next = forced_input_levels_reg;
      `DFM_IDX_MON_IN:    par_rdata_next = 16'(monitored_input_levels_reg);
      default:            par_rdata_next = 16'h0000;
    endcase
  end

  // Forcing is not kept over a restart; reset returns to terminals.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      io_forcing_select_reg   <= `DFM_FORCE_SEL_RST;
      forced_input_levels_reg <= `DFM_FORCED_IN_RST;
      par_rdata_reg           <= 16'h0000;
    end else begin
      io_forcing_select_reg   <= force_sel_next;
      forced_input_levels_reg <= forced_input_levels_next;
      par_rdata_reg           <= par_rdata_next;
    end
  end

  // Unknown selection values fall back to no forcing.
  always_comb begin
    case (io_forcing_select_reg)
      `DFM_FSEL_NONE: mode = DFM_MODE_NONE;
      `DFM_FSEL_IN:   mode = DFM_MODE_IN;
      `DFM_FSEL_OUT:  mode = DFM_MODE_OUT;
      `DFM_FSEL_BOTH: mode = DFM_MODE_BOTH;
      `DFM_FSEL_BUS:  mode = DFM_MODE_BUS;
      default:        mode = DFM_MODE_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input sampling and function map.

  logic [NUM_DI-1:0] levels_next; // Next sampled levels.
  logic [NUM_DI-1:0] di_act;      // Active flag per terminal.
  dfm_in_fn_t        in_fn_next;  // Next function commands.
  logic [7:0]        fn_act;      // Active flag per function slot.
  logic [2:0]        term;        // Terminal number of one slot.

  // One registered source feeds every function, so a source change lands
  // on all of them at the same sample and no mixed state can appear.
  always_comb begin
    if (mode == DFM_MODE_IN || mode == DFM_MODE_BOTH) begin
      levels_next = forced_input_levels_reg[NUM_DI-1:0];
    end else begin
      levels_next = di_pin;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      monitored_input_levels_reg <= '0;
    end else begin
      monitored_input_levels_reg <= levels_next;
    end
  end

  // Polarity turns levels into activity, then the table picks terminals.
  always_comb begin
    di_act = monitored_input_levels_reg ^ di_active_low;
    fn_act = 8'h00;
    term   = 3'h0;
    for (int f = 0; f < `DFM_NUM_IN_FN; f++) begin
      term = in_fn_map[f*3 +: 3];
      if (term != 3'h0 && int'(term) <= NUM_DI) begin
        fn_act[f] = di_act[term - 3'h1];
      end
    end
    in_fn_next.servo_enable     = fn_act[`DFM_FN_SERVO_EN] & ~bus_control_mode;
    in_fn_next.fault_clear      = fn_act[`DFM_FN_FAULT_CLR] & ~bus_control_mode;
    in_fn_next.forward_inhibit  = fn_act[`DFM_FN_FWD_LIMIT];
    in_fn_next.reverse_inhibit  = fn_act[`DFM_FN_REV_LIMIT];
    in_fn_next.homing_reference = fn_act[`DFM_FN_HOME_REF];
    in_fn_next.emergency_halt   = fn_act[`DFM_FN_EMERG_HALT];
    // The probe engine only sees an arming level here, never a capture.
    in_fn_next.latch_arm_a      = fn_act[`DFM_FN_LATCH_A];
    in_fn_next.latch_arm_b      = fn_act[`DFM_FN_LATCH_B];
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      in_fn_reg <= '0;
    end else begin
      in_fn_reg <= in_fn_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output functions and forcing.

  logic [NUM_DO-1:0] do_act;    // Function activity per output.
  logic [NUM_DO-1:0] do_next;   // Next terminal levels.
  logic              rotating;  // Speed has reached threshold.
  logic              safe_off;  // Both safe torque off supplies lost.

  // Outputs are level = activity xor polarity; bus forcing sets levels.
  always_comb begin
    rotating = drive_status.speed_abs >= rotation_speed_threshold;
    safe_off = ~drive_status.sto_a_powered & ~drive_status.sto_b_powered;
    do_act   = '0;
    do_next  = '0;
    for (int d = 0; d < NUM_DO; d++) begin
      case (do_fn_code[d*6 +: 6])
        `DFM_DO_READY:    do_act[d] = drive_status.ready;
        `DFM_DO_ROTATING: do_act[d] = rotating;
        `DFM_DO_BRAKE:    do_act[d] = drive_status.brake;
        `DFM_DO_WARN:     do_act[d] = drive_status.warning;
        `DFM_DO_FAULT:    do_act[d] = drive_status.fault;
        `DFM_DO_COMPARE:  do_act[d] = drive_status.cmp_passed;
        `DFM_DO_SAFETY:   do_act[d] = safe_off;
        default:          do_act[d] = 1'b0;
      endcase
      if (mode == DFM_MODE_OUT || mode == DFM_MODE_BOTH) begin
        do_act[d] = forced_do_active[d];
      end
      do_next[d] = do_act[d] ^ do_active_low[d];
      // Outputs without an enable bit keep their normal function.
      if (mode == DFM_MODE_BUS && fieldbus_out_en[`DFM_BUS_DO_LSB + d]) begin
        do_next[d] = fieldbus_out_val[`DFM_BUS_DO_LSB + d];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      do_pin_reg <= '0;
    end else begin
      do_pin_reg <= do_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_sel_write(logic [15:0] v);
    par_wr && par_idx == `DFM_IDX_FORCE_SEL && par_wdata == v;
  endsequence

  chk_sel_reset: assert property (@(posedge mclk)
    !rst_n |=> io_forcing_select_reg == 16'h0000)
    else $error("forcing selection not cleared by reset");

  chk_sel_write: assert property (@(posedge mclk) disable iff (!rst_n)
    s_sel_write(`DFM_FSEL_IN) |=> io_forcing_select_reg == `DFM_FSEL_IN
      ##1 (monitored_input_levels_reg == forced_input_levels_reg[NUM_DI-1:0]
           || $past(par_wr)))
    else $error("written selection did not take effect");

  chk_force_in: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == DFM_MODE_BOTH) |=>
      monitored_input_levels_reg == $past(forced_input_levels_reg[NUM_DI-1:0]))
    else $error("forced inputs not taken from forced value");

  chk_term_in: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == DFM_MODE_NONE) |=> monitored_input_levels_reg == $past(di_pin))
    else $error("terminal levels not used without forcing");

  chk_servo_bus: assert property (@(posedge mclk) disable iff (!rst_n)
    bus_control_mode |=> !in_fn_reg.servo_enable && !in_fn_reg.fault_clear)
    else $error("servo enable or fault clear active in bus mode");

  chk_unassigned: assert property (@(posedge mclk) disable iff (!rst_n)
    in_fn_map[`DFM_FN_FWD_LIMIT*3 +: 3] == 3'h0 |=> !in_fn_reg.forward_inhibit)
    else $error("unassigned function reads active");

  chk_safety_out: assert property (@(posedge mclk) disable iff (!rst_n)
    (do_fn_code[5:0] == `DFM_DO_SAFETY && mode == DFM_MODE_NONE &&
     (drive_status.sto_a_powered || drive_status.sto_b_powered))
      |=> do_pin_reg[0] == $past(do_active_low[0]))
    else $error("safety output active with a supply present");

  chk_rotating: assert property (@(posedge mclk) disable iff (!rst_n)
    (do_fn_code[5:0] == `DFM_DO_ROTATING && mode == DFM_MODE_NONE &&
     drive_status.speed_abs >= rotation_speed_threshold)
      |=> do_pin_reg[0] == ~$past(do_active_low[0]))
    else $error("rotating output missed threshold");

  chk_bus_force: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == DFM_MODE_BUS && fieldbus_out_en[`DFM_BUS_DO_LSB])
      |=> do_pin_reg[0] == $past(fieldbus_out_val[`DFM_BUS_DO_LSB]))
    else $error("bus forced output level wrong");

  chk_fault_out: assert property (@(posedge mclk) disable iff (!rst_n)
    (do_fn_code[5:0] == `DFM_DO_FAULT && mode == DFM_MODE_NONE)
      |=> do_pin_reg[0] == ($past(drive_status.fault) ^ $past(do_active_low[0])))
    else $error("fault output does not follow fault");

  // Emergency halt is a plain level from its terminal; stopping is left to the core.
  chk_halt_level: assert property (@(posedge mclk) disable iff (!rst_n)
    in_fn_map[`DFM_FN_EMERG_HALT*3 +: 3] == 3'h1
      |=> in_fn_reg.emergency_halt ==
          ($past(monitored_input_levels_reg[0]) ^ $past(di_active_low[0])))
    else $error("emergency halt does not follow terminal 1");

  // Outside bus control the servo enable command tracks its terminal.
  chk_servo_local: assert property (@(posedge mclk) disable iff (!rst_n)
    (!bus_control_mode && in_fn_map[`DFM_FN_SERVO_EN*3 +: 3] == 3'h1)
      |=> in_fn_reg.servo_enable ==
          ($past(monitored_input_levels_reg[0]) ^ $past(di_active_low[0])))
    else $error("servo enable does not follow terminal 1");

  // Selections 2 and 3 take output activity from the forced port.
  chk_forced_out: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == DFM_MODE_OUT || mode == DFM_MODE_BOTH)
      |=> do_pin_reg[0] == ($past(forced_do_active[0]) ^ $past(do_active_low[0])))
    else $error("forced output activity not applied");

  // Ready function on output 1 follows the drive ready flag.
  chk_ready_out: assert property (@(posedge mclk) disable iff (!rst_n)
    (do_fn_code[5:0] == `DFM_DO_READY && mode == DFM_MODE_NONE)
      |=> do_pin_reg[0] == ($past(drive_status.ready) ^ $past(do_active_low[0])))
    else $error("ready output does not follow drive ready");

endmodule
`default_nettype wire

// ---- hdl/dfm_defs.svh ----
// Constants of the digital input and output function map.
`ifndef DFM_DEFS_SVH
`define DFM_DEFS_SVH
// Parameter port indices.
`define DFM_IDX_FORCE_SEL   2'h0
`define DFM_IDX_FORCED_IN   2'h1
`define DFM_IDX_MON_IN      2'h2
// Reset value of the forcing selection.
`define DFM_FORCE_SEL_RST   16'h0000
// Reset value of the forced input levels.
`define DFM_FORCED_IN_RST   16'h0000
// Forcing selection codes.
`define DFM_FSEL_NONE       16'h0000
`define DFM_FSEL_IN         16'h0001
`define DFM_FSEL_OUT        16'h0002
`define DFM_FSEL_BOTH       16'h0003
`define DFM_FSEL_BUS        16'h0004
// Output function codes.
`define DFM_DO_READY        6'h01
`define DFM_DO_ROTATING     6'h02
`define DFM_DO_BRAKE        6'h09
`define DFM_DO_WARN         6'h0a
`define DFM_DO_FAULT        6'h0b
`define DFM_DO_COMPARE      6'h19
`define DFM_DO_SAFETY       6'h20
// Lowest bit of the fieldbus output object used for output 1.
`define DFM_BUS_DO_LSB      16
// Input function slots in the assignment table.
`define DFM_FN_SERVO_EN     0
`define DFM_FN_FAULT_CLR    1
`define DFM_FN_FWD_LIMIT    2
`define DFM_FN_REV_LIMIT    3
`define DFM_FN_HOME_REF     4
`define DFM_FN_EMERG_HALT   5
`define DFM_FN_LATCH_A      6
`define DFM_FN_LATCH_B      7
`define DFM_NUM_IN_FN       8
`endif

// ---- hdl/dfm_pkg.sv ----
// Types of the digital input and output function map.
`default_nettype none
package dfm_pkg;
  // Decoded forcing selection.
  typedef enum logic [2:0] {
    DFM_MODE_NONE,
    DFM_MODE_IN,
    DFM_MODE_OUT,
    DFM_MODE_BOTH,
    DFM_MODE_BUS
  } dfm_mode_t;
  // Internal drive status feeding the output functions.
  typedef struct packed {
    logic        ready;          // Drive is ready to run.
    logic        brake;          // Brake signal is being output.
    logic        warning;        // A warning is present.
    logic        fault;          // A fault is present.
    logic        cmp_passed;     // Target comparison point has been passed.
    logic        sto_a_powered;  // First safe torque off input has its supply.
    logic        sto_b_powered;  // Second safe torque off input has its supply.
    logic [15:0] speed_abs;      // Absolute filtered motor speed.
  } dfm_status_t;
  // Input function commands towards the drive core.
  typedef struct packed {
    logic servo_enable;          // Motor enabled.
    logic fault_clear;           // Latched fault reset.
    logic forward_inhibit;       // Forward motion inhibited.
    logic reverse_inhibit;       // Reverse motion inhibited.
    logic homing_reference;      // Load inside home switch range.
    logic emergency_halt;        // Stop at zero speed and hold.
    logic latch_arm_a;           // First probe capture allowed.
    logic latch_arm_b;           // Second probe capture allowed.
  } dfm_in_fn_t;
endpackage
`default_nettype wire

// ---- tb/dfm_field_model.sv ----
// Terminal switch model standing in front of the five input terminals.
`timescale 1ns/100ps
`default_nettype none
module dfm_field_model (
  input  wire logic [4:0] sw_level,  // Switch levels commanded by the host side.
  output logic      [4:0] di_pin     // Levels seen at the terminals.
);
  ////////////////////////////////////////////////////////////////////////////////
  // Switches are wired straight through; contact bounce is left out because the
  // block samples levels and bounce would only hide the latency being checked.
  assign di_pin = sw_level;
endmodule
`default_nettype wire

// ---- tb/dfm_top_bench.sv ----
// Self-checking bench for the digital input and output function map.
`timescale 1ns/100ps
`default_nettype none
module dfm_top_bench;
  import dfm_pkg::*;
  logic        mclk = 1'b0;        // Control clock.
  logic        rst_n = 1'b0;       // Synchronous reset, active low.
  logic [4:0]  sw = 5'h00;         // Switch levels.
  logic [4:0]  act_lo = 5'h00;     // Input polarity.
  logic [23:0] map = 24'h08d8d1;   // Slots 0..4 to terminals 1..5, 5 to 1, 6 to 2, 7 unused.
  logic [17:0] docode = 18'h00000; // Output function codes.
  logic [2:0]  dolo = 3'h0;        // Output polarity.
  logic [2:0]  fdo = 3'h0;         // Forced output activity.
  logic [31:0] fen = 32'h0;        // Fieldbus enable object.
  logic [31:0] fval = 32'h0;       // Fieldbus value object.
  logic        busm = 1'b0;        // Bus control mode.
  logic [15:0] thr = 16'h0100;     // Rotation threshold.
  dfm_status_t st = '0;            // Drive status.
  logic        wr = 1'b0;          // Parameter write strobe.
  logic [1:0]  idx = 2'h0;         // Parameter index.
  logic [15:0] wd = 16'h0;         // Parameter write data.
  logic [15:0] rdata;              // Parameter read data.
  dfm_in_fn_t  infn;               // Input function commands.
  logic [2:0]  dop;                // Output terminal levels.
  logic [15:0] sel;                // Forcing selection.
  wire  [4:0]  di;                 // Terminal levels from the switch model.
  int          failures = 0;       // Mismatches seen.
  int          compares = 0;       // Comparisons made.
  int          cycles = 0;         // Watchdog count.
  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 200 MHz and instances.
  always #2.5 mclk = ~mclk;
  dfm_field_model field (.sw_level(sw), .di_pin(di));
  dfm_top DUT (.mclk(mclk), .rst_n(rst_n), .di_pin(di), .di_active_low(act_lo),
    .in_fn_map(map), .do_fn_code(docode), .do_active_low(dolo), .forced_do_active(fdo),
    .fieldbus_out_en(fen), .fieldbus_out_val(fval), .bus_control_mode(busm),
    .rotation_speed_threshold(thr), .drive_status(st), .par_wr(wr), .par_idx(idx),
    .par_wdata(wd), .par_rdata_reg(rdata), .in_fn_reg(infn), .do_pin_reg(dop),
    .io_forcing_select_reg(sel));
  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks; inputs always move 1 ns after the rising edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic pw(input logic [1:0] i, input logic [15:0] d);
    wr = 1'b1;
    idx = i;
    wd = d;
    cyc(1);
    wr = 1'b0;
  endtask
  task automatic rd(input logic [1:0] i, input logic [15:0] exp, input string name);
    idx = i;
    cyc(1);
    check(name, rdata, exp);
  endtask
  // Expected commands from active terminals; slot 0 lands in the top bit.
  function automatic logic [7:0] exp_fn(input logic [4:0] act, input logic bm);
    logic [2:0] t;
    logic [7:0] e;
    e = 8'h00;
    for (int f = 0; f < 8; f++) begin
      t = map[3*f +: 3];
      e[7-f] = (t >= 3'h1 && t <= 3'h5) ? act[t-1] : 1'b0;
      if (bm && f < 2) begin
        e[7-f] = 1'b0;
      end
    end
    return e;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Each terminal alone, both polarities, with bus mode gating, then an unassigned slot.
  task automatic t_inputs;
    for (int p = 0; p < 2; p++) begin
      act_lo = p ? 5'h1f : 5'h00;
      for (int t = 0; t < 5; t++) begin
        sw = p ? ~(5'h01 << t) : (5'h01 << t);
        busm = t[0] ^ p[0];
        cyc(2);
        check("in_fn", {8'h00, infn}, {8'h00, exp_fn(5'h01 << t, busm)});
        rd(2'h2, {11'h000, sw}, "mon_levels");
      end
    end
    busm = 1'b0;
    // Forward limit slot left unassigned: its terminal must drive nothing.
    map = 24'h08d811;
    act_lo = 5'h00;
    sw = 5'h04;
    cyc(2);
    check("unassigned", {8'h00, infn}, 16'h0000);
    map = 24'h08d8d1;
    $display("test inputs done");
  endtask
  // Forced input levels hide the terminals until the selection returns to 0.
  task automatic t_force_in;
    act_lo = 5'h1f;
    pw(2'h1, 16'h001e);
    cyc(1);
    pw(2'h0, 16'h0001);
    check("sel", sel, 16'h0001);
    sw = 5'h01;
    cyc(2);
    check("in_fn", {8'h00, infn}, {8'h00, exp_fn(5'h01, 1'b0)});
    rd(2'h2, 16'h001e, "mon_forced");
    rd(2'h0, 16'h0001, "sel_read");
    rd(2'h3, 16'h0000, "idx3_read");
    pw(2'h0, 16'h0000);
    sw = 5'h1f;
    cyc(2);
    check("in_fn", {8'h00, infn}, 16'h0000);
    rd(2'h2, 16'h001f, "mon_terminal");
    $display("test force_in done");
  endtask
  // Every output code, active and inactive, on output 1.
  task automatic t_outputs;
    logic [5:0] codes [8] = '{6'h01, 6'h02, 6'h09, 6'h0a, 6'h0b, 6'h19, 6'h20, 6'h3f};
    for (int c = 0; c < 8; c++) begin
      for (int on = 0; on < 2; on++) begin
        docode = {6'h01, 6'h01, codes[c]};
        st = '0;
        st.sto_a_powered = 1'b1;
        st.sto_b_powered = 1'b1;
        st.speed_abs = on ? 16'h0100 : 16'h00ff;
        case (codes[c])
          6'h01: st.ready = on[0];
          6'h09: st.brake = on[0];
          6'h0a: st.warning = on[0];
          6'h0b: st.fault = on[0];
          6'h19: st.cmp_passed = on[0];
          6'h20: begin
            st.sto_a_powered = on ? 1'b0 : 1'b1;
            st.sto_b_powered = 1'b0;
          end
          default: st.ready = 1'b1;
        endcase
        cyc(2);
        check("do_pin0", {15'h0000, dop[0]}, {15'h0000, on[0] && codes[c] != 6'h3f});
      end
    end
    $display("test outputs done");
  endtask
  // Forced outputs from the port, then from the fieldbus object bits.
  task automatic t_force_out;
    st = '0;
    st.ready = 1'b1;
    docode = {6'h01, 6'h01, 6'h01};
    dolo = 3'h1;
    fdo = 3'h5;
    pw(2'h0, 16'h0002);
    cyc(1);
    check("do_forced", {13'h0000, dop}, 16'h0004);
    pw(2'h0, 16'h0003);
    cyc(1);
    check("do_both", {13'h0000, dop}, 16'h0004);
    rd(2'h2, 16'h001e, "mon_both");
    fen = 32'h00030000;
    fval = 32'h00010000;
    pw(2'h0, 16'h0004);
    cyc(1);
    check("do_bus", {13'h0000, dop}, 16'h0005);
    pw(2'h0, 16'h0000);
    cyc(1);
    check("do_normal", {13'h0000, dop}, 16'h0006);
    $display("test force_out done");
  endtask
  // Restart while both forcings run: everything returns to the terminals.
  task automatic t_restart;
    pw(2'h0, 16'h0003);
    rst_n = 1'b0;
    cyc(2);
    check("do_reset", {13'h0000, dop}, 16'h0000);
    check("in_fn_reset", {8'h00, infn}, 16'h0000);
    rst_n = 1'b1;
    sw = 5'h0a;
    cyc(1);
    check("sel_restart", sel, 16'h0000);
    rd(2'h2, 16'h000a, "mon_restart");
    $display("test restart done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and watchdog.
  task automatic print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    cyc(8);
    rst_n = 1'b1;
    cyc(1);
    check("sel_reset", sel, 16'h0000);
    t_inputs();
    t_force_in();
    t_outputs();
    t_force_out();
    t_restart();
    print_verdict();
  end
endmodule
`default_nettype wire
